// ---- rsc_defines.svh ----
// Purpose: constants for the serial channel
// Assumes: 40 MHz sys_clk
// Notes:   offsets are host I/O port numbers
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH
`define RSC_DATA_PORT        8'h8C
`define RSC_STATUS_PORT      8'h8D
`define RSC_CMD_TX_EN        0
`define RSC_CMD_DTR          1
`define RSC_CMD_RX_EN        2
`define RSC_CMD_ERR_RESET    4
`define RSC_CMD_RTS          5
`define RSC_CMD_SOFT_RESET   6
`define RSC_ST_TX_READY      0
`define RSC_ST_RX_READY      1
`define RSC_ST_TX_EMPTY      2
`define RSC_ST_PARITY_ERR    3
`define RSC_ST_OVERRUN       4
`define RSC_ST_FRAMING_ERR   5
`define RSC_ST_BREAK         6
`define RSC_ST_DSR           7
`define RSC_CLK_HZ           40000000
`define RSC_BASE_CLK_19200   (19200 * 16)
`define RSC_BASE_CLK_9600    (9600 * 16)
`define RSC_BASE_CLK_2400    (2400 * 16)
`define RSC_BASE_CLK_1200    (1200 * 16)
`define RSC_TICK_DIV(hz)     (`RSC_CLK_HZ / (hz))
`define RSC_IRQ_VECTOR_SLOT  8'hFE
`endif

// ---- rsc_pkg.sv ----
// Purpose: types for the serial channel
// Assumes: nothing
// Notes:   state held as one packed struct
`default_nettype none
package rsc_pkg;
	typedef enum logic [2:0] {
		RSC_TX_IDLE  = 3'b001,
		RSC_TX_SHIFT = 3'b010,
		RSC_TX_STOP  = 3'b100
	} rsc_tx_state_t;
	typedef enum logic [2:0] {
		RSC_RX_IDLE  = 3'b001,
		RSC_RX_SHIFT = 3'b010,
		RSC_RX_STOP  = 3'b100
	} rsc_rx_state_t;
	typedef struct packed {
		logic       sel;
		logic       rd;
		logic       wr;
		logic       port;
		logic [7:0] wdata;
	} rsc_bus_t;
	typedef struct packed {
		logic       mode_done;
		logic [7:0] mode;
		logic [7:0] cmd;
		logic [11:0] base_cnt;
		logic       tick;
		logic [5:0] tx_sub;
		rsc_tx_state_t tx_st;
		logic [10:0] tx_sh;
		logic [3:0] tx_bits;
		logic [7:0] tx_hold;
		logic       tx_full;
		logic       txd;
		logic [5:0] rx_sub;
		rsc_rx_state_t rx_st;
		logic [9:0] rx_sh;
		logic [3:0] rx_bits;
		logic [2:0] rxd_sync;
		logic [2:0] cts_sync;
		logic [2:0] dsr_sync;
		logic       rxd;
		logic       cts;
		logic       dsr;
		logic [7:0] rx_data;
		logic       rx_ready;
		logic       pe;
		logic       oe;
		logic       fe;
		logic       brk;
		logic [11:0] brk_cnt;
		logic [7:0] rdata;
		logic       irq;
		logic       rts_n;
		logic       dtr_n;
	} rsc_state_t;
endpackage
`default_nettype wire

// ---- rsc_channel.sv ----
// Purpose: asynchronous RS-232 serial channel on the host I/O bus
// Assumes: one-cycle rd/wr strobes from the host bus, same clock
// Notes:   base rate from two port pins, 16X or 64X factor, async only
`include "rsc_defines.svh"
`default_nettype none

module rsc_channel
	import rsc_pkg::*;
#(
	parameter int unsigned CLK_HZ = `RSC_CLK_HZ
)
(
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire rsc_bus_t   bus,
	input  wire logic       base_rate_select_high,
	input  wire logic       base_rate_select_low,
	input  wire logic       rxd_pin,
	input  wire logic       cts_n_pin,
	input  wire logic       dsr_n_pin,
	output var  logic [7:0] rdata,
	output var  logic       irq,
	output var  logic       txd_pin,
	output var  logic       rts_n_pin,
	output var  logic       dtr_n_pin
);
	localparam logic [11:0] DIV_19200 = 12'(CLK_HZ / `RSC_BASE_CLK_19200);
	localparam logic [11:0] DIV_9600  = 12'(CLK_HZ / `RSC_BASE_CLK_9600);
	localparam logic [11:0] DIV_2400  = 12'(CLK_HZ / `RSC_BASE_CLK_2400);
	localparam logic [11:0] DIV_1200  = 12'(CLK_HZ / `RSC_BASE_CLK_1200);
	// table slot that the host fills with this channel's service routine
	localparam logic [7:0]  VECTOR_SLOT = `RSC_IRQ_VECTOR_SLOT;

	// ----------------------------------------------------------------
	// build checks
	// ----------------------------------------------------------------
	// the 12-bit divider must reach the slowest rate and still split the fastest
	if (CLK_HZ / `RSC_BASE_CLK_1200 > 4095) begin : g_clk_fast
		$error("sys_clk too fast for the 12-bit rate divider");
	end
	if (CLK_HZ / `RSC_BASE_CLK_19200 < 2) begin : g_clk_slow
		$error("sys_clk too slow for the fastest base rate");
	end

	rsc_state_t s;
	rsc_state_t next_s;

	logic [11:0] div_sel;
	logic [5:0]  sub_top;
	logic [3:0]  data_bits;
	logic        par_en;
	logic        par_even;
	logic        two_stop;
	logic        tx_ready;
	logic        tx_empty;
	logic [7:0]  status;
	logic        rd_data;
	logic        wr_data;
	logic        wr_ctrl;
	logic        rx_par;
	logic [7:0]  rx_byte;
	logic [7:0]  data_mask;
	logic        tx_par;

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	always_comb begin
		// shared by both directions, so they can never drift apart
		unique case ({base_rate_select_high, base_rate_select_low})
			2'b10:   div_sel = DIV_19200;
			2'b11:   div_sel = DIV_9600;
			2'b01:   div_sel = DIV_2400;
			default: div_sel = DIV_1200;
		endcase
		// 64X gives a quarter of the base rate; 1X falls back to 16X
		sub_top   = (s.mode[1:0] == 2'b11) ? 6'd63 : 6'd15;
		data_bits = 4'd5 + {2'b00, s.mode[3:2]};
		par_en    = s.mode[4];
		par_even  = s.mode[5];
		two_stop  = s.mode[7];
		tx_ready  = !s.tx_full;
		tx_empty  = tx_ready && (s.tx_st == RSC_TX_IDLE);
		// status bits, msb first
		status[7] = s.dsr;
		status[6] = s.brk;
		status[5] = s.fe;
		status[4] = s.oe;
		status[3] = s.pe;
		status[2] = tx_empty;
		status[1] = s.rx_ready;
		status[0] = tx_ready && s.cts;
		rd_data   = bus.sel && bus.rd && !bus.port;
		wr_data   = bus.sel && bus.wr && !bus.port;
		wr_ctrl   = bus.sel && bus.wr && bus.port;
		// a whole frame ends at the top of the shifter: stop, parity, data
		data_mask = 8'hFF >> (4'd8 - data_bits);
		rx_byte   = 8'(s.rx_sh >> (4'd9 - data_bits - {3'b000, par_en})) & data_mask;
		rx_par    = ^rx_byte ^ !par_even;
		tx_par    = ^(s.tx_hold & data_mask) ^ !par_even;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		// pins are asynchronous; a level counts once the last two stages agree,
		// so one metastable sample can never reach the receiver
		next_s.rxd_sync = {s.rxd_sync[1:0], rxd_pin};
		next_s.cts_sync = {s.cts_sync[1:0], !cts_n_pin};
		next_s.dsr_sync = {s.dsr_sync[1:0], !dsr_n_pin};
		if (s.rxd_sync[2] == s.rxd_sync[1]) next_s.rxd = s.rxd_sync[2];
		if (s.cts_sync[2] == s.cts_sync[1]) next_s.cts = s.cts_sync[2];
		if (s.dsr_sync[2] == s.dsr_sync[1]) next_s.dsr = s.dsr_sync[2];

		// one divider feeds both directions
		next_s.tick = 1'b0;
		if (s.base_cnt >= div_sel - 12'd1) begin
			next_s.base_cnt = '0;
			next_s.tick     = 1'b1;
		end else begin
			next_s.base_cnt = s.base_cnt + 12'd1;
		end

		// ----------------------------------------------------------------
		// host access
		// ----------------------------------------------------------------
		// mode and command share one port, told apart by the mode_done flag
		if (wr_ctrl) begin
			if (!s.mode_done) begin
				next_s.mode      = bus.wdata;
				next_s.mode_done = 1'b1;
			end else if (bus.wdata[`RSC_CMD_SOFT_RESET]) begin
				next_s.mode_done = 1'b0;
				next_s.cmd       = '0;
			end else begin
				next_s.cmd = bus.wdata;
				if (bus.wdata[`RSC_CMD_ERR_RESET]) begin
					next_s.pe = 1'b0;
					next_s.oe = 1'b0;
					next_s.fe = 1'b0;
				end
			end
		end
		if (wr_data) begin
			next_s.tx_hold = bus.wdata;
			next_s.tx_full = 1'b1;
		end
		// read data stays put until the next read of either port
		if (bus.sel && bus.rd) next_s.rdata = bus.port ? status : s.rx_data;
		if (rd_data) next_s.rx_ready = 1'b0;
		next_s.rts_n = !s.cmd[`RSC_CMD_RTS];
		next_s.dtr_n = !s.cmd[`RSC_CMD_DTR];

		// ----------------------------------------------------------------
		// transmitter
		// ----------------------------------------------------------------
		// waits for enable, clear-to-send and a mode word before it starts
		unique case (s.tx_st)
			RSC_TX_IDLE: begin
				next_s.txd = 1'b1;
				if (s.tx_full && s.cmd[`RSC_CMD_TX_EN] && s.cts && s.mode_done) begin
					// parity waits in bit 8 while the data bits go out by index
					next_s.tx_sh   = {2'b11, tx_par, s.tx_hold};
					next_s.tx_bits = '0;
					next_s.tx_sub  = '0;
					// a write in this very cycle refills the holding register
					next_s.tx_full = wr_data;
					next_s.txd     = 1'b0;
					next_s.tx_st   = RSC_TX_SHIFT;
				end
			end
			RSC_TX_SHIFT: if (s.tick) begin
				next_s.tx_sub = s.tx_sub + 6'd1;
				if (s.tx_sub == sub_top) begin
					next_s.tx_sub  = '0;
					next_s.txd     = s.tx_sh[s.tx_bits[2:0]];
					next_s.tx_bits = s.tx_bits + 4'd1;
					if (s.tx_bits == data_bits - 4'd1) begin
						next_s.tx_st   = RSC_TX_STOP;
						next_s.tx_bits = '0;
					end
				end
			end
			RSC_TX_STOP: if (s.tick) begin
				next_s.tx_sub = s.tx_sub + 6'd1;
				if (s.tx_sub == sub_top) begin
					next_s.tx_sub  = '0;
					next_s.txd     = (par_en && s.tx_bits == 4'd0) ? s.tx_sh[8] : 1'b1;
					next_s.tx_bits = s.tx_bits + 4'd1;
					// leave only once the last stop bit has had its full time
					if (s.tx_bits == {3'b000, par_en} + {3'b000, two_stop} + 4'd1)
						next_s.tx_st = RSC_TX_IDLE;
				end
			end
			default: next_s.tx_st = RSC_TX_IDLE;
		endcase

		// ----------------------------------------------------------------
		// receiver, sampling mid-bit
		// ----------------------------------------------------------------
		// break: line low for about two full frames of sub-bit ticks
		if (s.rxd) begin
			next_s.brk_cnt = 12'd0;
		end else if (s.tick && s.brk_cnt != 12'hFFF) begin
			next_s.brk_cnt = s.brk_cnt + 12'd1;
		end
		next_s.brk = (s.brk_cnt >= {sub_top, 1'b0} * 12'd11);
		unique case (s.rx_st)
			RSC_RX_IDLE: if (s.tick && !s.rxd && s.cmd[`RSC_CMD_RX_EN]) begin
				next_s.rx_sub  = {1'b0, sub_top[5:1]};
				next_s.rx_bits = '0;
				next_s.rx_st   = RSC_RX_SHIFT;
			end
			RSC_RX_SHIFT: if (s.tick) begin
				next_s.rx_sub = s.rx_sub + 6'd1;
				if (s.rx_sub == sub_top) begin
					next_s.rx_sub = '0;
					next_s.rx_sh  = {s.rxd, s.rx_sh[9:1]};
					next_s.rx_bits = s.rx_bits + 4'd1;
					if (s.rx_bits == 4'd0 && s.rxd) next_s.rx_st = RSC_RX_IDLE;
					// the stop bit is sampled too, so framing can be judged
					if (s.rx_bits == data_bits + {3'b000, par_en} + 4'd1)
						next_s.rx_st = RSC_RX_STOP;
				end
			end
			RSC_RX_STOP: begin
				next_s.rx_data  = rx_byte;
				next_s.pe       = s.pe | (par_en && (rx_par != s.rx_sh[8]));
				next_s.fe       = s.fe | !s.rx_sh[9];
				next_s.oe       = s.oe | s.rx_ready;
				next_s.rx_ready = 1'b1;
				next_s.rx_st    = RSC_RX_IDLE;
			end
			default: next_s.rx_st = RSC_RX_IDLE;
		endcase

		// shared request; host polls status to tell the two apart
		// built from next values so a cleared cause drops it without delay
		next_s.irq = (next_s.rx_ready && next_s.cmd[`RSC_CMD_RX_EN])
			|| (!next_s.tx_full && next_s.cmd[`RSC_CMD_TX_EN]);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// reset values keep the line idle at mark and the modem outputs off
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s <= '0;
			s.tx_st <= RSC_TX_IDLE;
			s.rx_st <= RSC_RX_IDLE;
			s.txd   <= 1'b1;
			s.rxd   <= 1'b1;
			s.rxd_sync <= 3'b111;
			s.rts_n <= 1'b1;
			s.dtr_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rdata     = s.rdata;
	assign irq       = s.irq;
	assign txd_pin   = s.txd;
	assign rts_n_pin = s.rts_n;
	assign dtr_n_pin = s.dtr_n;
endmodule
`default_nettype wire

// ---- rsc_channel_assertions.sv ----
// Purpose: port checks for rsc_channel
// Assumes: command bits shadowed from bus writes
// Notes:   bound at the foot of this file
`default_nettype none
module rsc_channel_assertions
	import rsc_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       srst,
	input wire rsc_bus_t   bus,
	input wire logic       irq,
	input wire logic [7:0] rdata,
	input wire logic       txd_pin,
	input wire logic       rts_n_pin,
	input wire logic       dtr_n_pin,
	input wire logic       cts_n_pin
);
	// ----
	// mode and command shadow
	// ----
	logic       mode_q;
	logic [7:0] cmd_q;
	wire        ctl_wr = bus.sel && bus.wr && bus.port;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mode_q <= 1'h0;
			cmd_q  <= 8'h00;
		end else if (ctl_wr && mode_q && bus.wdata[6]) begin
			// soft reset command: back to waiting for a mode word
			mode_q <= 1'h0;
			cmd_q  <= 8'h00;
		end else if (ctl_wr) begin
			mode_q <= 1'h1;
			cmd_q  <= mode_q ? bus.wdata : 8'h00;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	sequence rd_data;
		bus.sel && bus.rd && !bus.port;
	endsequence
	sequence tx_load;
		bus.sel && bus.wr && !bus.port && cmd_q[0] && !cts_n_pin && txd_pin;
	endsequence
	a_reset_idle:
		assert property (disable iff (1'h0) srst |=> txd_pin && rts_n_pin && dtr_n_pin && !irq)
		else $error("outputs not idle after reset");
	a_irq_gated:
		assert property (!cmd_q[0] && !cmd_q[2] && !ctl_wr |=> !irq)
		else $error("irq with enables clear");
	a_rdata_held:
		assert property (!(bus.sel && bus.rd) |=> $stable(rdata)) else $error("rdata moved");
	a_read_clears:
		assert property (rd_data ##1 !cmd_q[0] |=> !irq) else $error("irq kept after read");
	a_tx_gated:
		assert property ($fell(txd_pin) |-> mode_q && cmd_q[0]) else $error("tx while disabled");
	a_modem_track:
		assert property ($stable(cmd_q) |-> rts_n_pin == !cmd_q[5] && dtr_n_pin == !cmd_q[1])
		else $error("modem outputs off");
	a_tx_irq:
		assert property (tx_load |=> ##[1:8] irq) else $error("no irq after tx load");
	a_start_len:
		assert property ($fell(txd_pin) |-> !txd_pin [*8]) else $error("start bit short");
endmodule
bind rsc_channel rsc_channel_assertions u_chk (.sys_clk, .srst, .bus, .irq, .rdata, .txd_pin,
	.rts_n_pin, .dtr_n_pin, .cts_n_pin);
`default_nettype wire

// ---- rsc_dce_model.sv ----
// Purpose: modem side stand-in for the serial channel
// Assumes: bit time given in clock cycles by the caller
// Notes:   modem lines stay asserted, rxd idles at mark
`default_nettype none
module rsc_dce_model (
	input  wire logic sys_clk,
	output var  logic rxd,
	output var  logic cts_n,
	output var  logic dsr_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// line drivers
	// ----
	initial begin
		rxd = 1'h1;
		cts_n = 1'h0;
		dsr_n = 1'h0;
	end
	task automatic hold(input logic v);
		@(posedge sys_clk);
		rxd <= v;
	endtask
	// start, eight data bits lsb first, one stop
	task automatic send(input logic [7:0] v, input int c);
		logic [9:0] f;
		f = {1'h1, v, 1'h0};
		for (int i = 0; i < 10; i++) begin
			hold(f[i]);
			repeat (c - 1) @(posedge sys_clk);
		end
	endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: self-checking bench for rsc_channel
// Assumes: 40 MHz clock, modem stand-in on the line side
// Notes:   rate rows time one start bit each to keep the run short
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
	$display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench import rsc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [1:0] pins; logic [7:0] mode; int base; int fac;} rsc_row_t;
	logic       sys_clk, srst, txd, irq, rts_n, dtr_n, rxd, cts_n, dsr_n;
	logic [1:0] rate;
	logic [7:0] rdata;
	rsc_bus_t   bus;
	int         bad_count, compares, n, e, d;
	rsc_row_t   rows [3] = '{'{2'h2, 8'h4E, 19200, 16}, '{2'h3, 8'h4E, 9600, 16},
		'{2'h2, 8'h4F, 19200, 64}};
	rsc_channel dut (.sys_clk, .srst, .bus, .base_rate_select_high(rate[1]),
		.base_rate_select_low(rate[0]), .rxd_pin(rxd), .cts_n_pin(cts_n), .dsr_n_pin(dsr_n),
		.rdata, .irq, .txd_pin(txd), .rts_n_pin(rts_n), .dtr_n_pin(dtr_n));
	rsc_dce_model dce (.sys_clk, .rxd, .cts_n, .dsr_n);
	always #12.5 sys_clk = ~sys_clk;
	// ----
	// bus and wait helpers
	// ----
	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic rst();
		@(posedge sys_clk);
		srst <= 1'h1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'h0;
	endtask
	task automatic acc(input logic p, input logic r, input logic [7:0] v);
		@(posedge sys_clk);
		bus <= '{sel: 1'h1, rd: r, wr: !r, port: p, wdata: v};
		@(posedge sys_clk);
		bus <= '0;
		@(posedge sys_clk);
		#1;
	endtask
	// s picks irq (1) or txd (0)
	task automatic wsig(input logic s, input logic v, input int lim);
		n = 0;
		while ((s ? irq : txd) !== v) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (n > lim) begin
				bad_count++;
				close_out();
			end
		end
	endtask
	initial begin
		sys_clk = 1'h0;
		srst = 1'h1;
		bus = '0;
		rate = 2'h2;
		repeat (6) @(posedge sys_clk);
		srst <= 1'h0;
		#1;
		`CHK({txd, rts_n, dtr_n, irq}, 4'hE)
		for (int k = 0; k < 3; k++) begin
			rst();
			rate <= rows[k].pins;
			acc(1'h1, 1'h0, rows[k].mode);
			acc(1'h1, 1'h0, 8'h23);
			acc(1'h0, 1'h0, 8'hFF);
			wsig(1'h0, 1'h0, 400);
			n = 0;
			while (txd === 1'h0 && n < 9000) begin
				@(posedge sys_clk);
				#1;
				n++;
			end
			if (n >= 9000) begin
				bad_count++;
				close_out();
			end
			e = rows[k].fac * (40000000 / (rows[k].base * 16));
			d = e / rows[k].fac;
			`CHK(n > e - d && n <= e, 1'h1)
			`CHK({irq, rts_n, dtr_n}, 3'h4)
			$display("rate row %0d done", k);
		end
		rst();
		acc(1'h1, 1'h0, 8'h4E);
		acc(1'h1, 1'h0, 8'h04);
		dce.send(8'hA5, 16 * (40000000 / 307200));
		wsig(1'h1, 1'h1, 4000);
		acc(1'h1, 1'h1, 8'h00);
		`CHK({rdata[7], rdata[1]}, 2'h3)
		acc(1'h0, 1'h1, 8'h00);
		`CHK(rdata, 8'hA5)
		repeat (560) @(posedge sys_clk);
		acc(1'h1, 1'h1, 8'h00);
		`CHK({irq, rdata[1]}, 2'h0)
		$display("receive test done");
		acc(1'h1, 1'h0, 8'h00);
		dce.hold(1'h0);
		d = 0;
		repeat (52000) begin
			@(posedge sys_clk);
			#1;
			if (irq !== 1'h0) d++;
		end
		`CHK(d, 0)
		acc(1'h1, 1'h1, 8'h00);
		`CHK(rdata[6], 1'h1)
		dce.hold(1'h1);
		$display("break test done");
		close_out();
	end
endmodule
`default_nettype wire
